/* tss_pkg.sv */
// shared constants and types for the test schedule sequencer
package tss_pkg;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_DUR = 4'h1;
  localparam logic [3:0] ADR_TINT = 4'h2;
  localparam logic [3:0] ADR_LINT = 4'h3;
  localparam logic [3:0] ADR_IGN = 4'h4;
  localparam logic [3:0] ADR_CONF = 4'h5;
  localparam logic [3:0] ADR_TIME = 4'h6;
  localparam logic [3:0] ADR_TNUM = 4'h7;
  localparam logic [3:0] ADR_STS = 4'h8;
  localparam logic [3:0] ADR_MSK = 4'h9;
  localparam logic [3:0] ADR_RES = 4'hA;
  localparam logic [3:0] ADR_SER = 4'hB;
  localparam logic [3:0] ADR_FW = 4'hC;
  localparam logic [3:0] ADR_CALL = 4'hD;
  localparam logic [3:0] ADR_CALD = 4'hE;
  localparam logic [3:0] ADR_CMD = 4'hF;
  // ctrl bit positions
  localparam int B_CONT = 0;
  localparam int B_LOGC = 1;
  localparam int B_STOPC = 2;
  localparam int B_CONFM = 3;
  localparam int B_SIM = 4;
  localparam int B_LFDIS = 5;
  localparam int B_FMT = 6;
  localparam int W_FMT = 2;
  localparam int W_CTRL = 8;
  // status bits
  localparam int E_DONE = 0;
  localparam int E_LOG = 1;
  localparam int E_CLEAN = 2;
  localparam int E_LOWC = 3;
  localparam int E_ALIGN = 4;
  localparam int W_EV = 5;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  // reset values and limits
  localparam logic [15:0] DUR_MIN = 16'h0002;
  localparam logic [15:0] DUR_RST = 16'h0078;
  localparam logic [15:0] MIN_PARTICLES = 16'h0014;
  localparam logic [15:0] TNUM_RST = 16'h0001;
  localparam longint SEC_NS = 1000000000;
  localparam longint CLK_NS = 5;
  localparam longint CYC_PER_SEC = SEC_NS / CLK_NS;
  typedef enum logic [1:0] {TSS_IDLE, TSS_RUN, TSS_WAIT} tss_state_e;
  typedef struct packed {
    logic [31:0] serial;
    logic [31:0] stamp;
    logic [15:0] num;
    logic [15:0] count;
    logic valid;
    logic clean;
  } tss_rec_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tss_req_s;
endpackage : tss_pkg

/* tss_core.sv */
// test scheduling, validation, logging and time keeping of the monitor
// Function
// - test number returns to its start value at every reset.
// - test length is configurable, two minutes by default; tests run exactly that.
// - one format setting drives result display and alarm target comparison.
// - simulated test runs tests and yields results without fluid flow.
// - low-flow alarm off: result valid only with 20 or more large particles.
// - low-flow alarm off: fewer than 20 large particles raises alarm and fault code.
// - continuous testing restarts tests on its own, paced by the interval.
// - interval above duration: new test at each interval expiry.
// - interval at or below duration: next test starts right away.
// - continuous without logging stores only the last test of a clean stop; a host stop stores none.
// - continuous logging stores only tests landing on the log interval; a clean stop's last test and, at interval 0, every test are stored too.
// - log interval must fall on a test boundary; otherwise flag error.
// - stop-when-clean tests until clean, then alarms and stops.
// - first configured number of tests after start are not logged.
// - confirm mode stops after N consecutive clean results; dirty resets.
// - each record carries serial number and current time as its key; a time not after the last record's stamp gets that stamp plus one.
// - host write of time overwrites the current time.
// - serial, firmware, calibration dates readable by host.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module tss_core
  import tss_pkg::*;
#(
  parameter longint SEC_CYCLES = tss_pkg::CYC_PER_SEC,
  parameter logic [31:0] SERIAL_NO = 32'h00000001, // arbitrary value
  parameter logic [31:0] FW_VER = 32'h00000100, // arbitrary value
  parameter logic [31:0] CAL_LAST = 32'h00000000,
  parameter logic [31:0] CAL_DUE = 32'h00000000
) (
  input wire logic clk, // 200 MHz clock
  input wire logic reset, // synchronous, active high
  input wire tss_pkg::tss_req_s req, // register request
  output logic [31:0] rdata, // read data, cycle after read
  input wire logic particle, // pulse pin, one per large particle
  input wire logic clean_hit, // comparator: result meets target
  output logic [tss_pkg::W_FMT-1:0] fmt, // result format to comparator
  output logic testing, // a test is accumulating
  output logic alarm, // clean stop or low count alarm
  output logic fault, // low particle count fault code
  output logic flow_ok, // flow reading may be shown
  output logic log_v, // one-cycle log strobe
  output tss_pkg::tss_rec_s log_rec, // record to store
  output logic irq // level interrupt
);
  import tss_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic [W_CTRL-1:0] ctrl;
    logic [15:0] dur;
    logic [15:0] tint;
    logic [15:0] lint;
    logic [7:0] ign;
    logic [7:0] conf;
    logic [31:0] now;
    logic [15:0] tnum;
    tss_state_e st;
    logic [31:0] div;
    logic [15:0] el;
    logic [15:0] icnt;
    logic [15:0] cnt;
    logic [7:0] ndone;
    logic [7:0] streak;
    logic [15:0] lacc;
    logic [W_EV-1:0] sts;
    logic [W_EV-1:0] msk;
    logic irq;
    logic alarm;
    logic fault;
    logic flow_ok;
    logic log_v;
    tss_rec_s rec;
    tss_rec_s last;
    logic [2:0] pin;
    logic [31:0] sub;
    logic testing;
  } tss_state_s;

  tss_state_s s_q, s_d;

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  logic tick;
  logic ttick;
  logic pulse;
  logic [15:0] step;
  logic [16:0] lsum;
  logic stop_now;
  logic do_log;
  logic clean_eff;
  logic [W_EV-1:0] ev;
  logic [W_EV-1:0] clr;
  logic [7:0] streak_n;

  always_comb
  begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    do_log = 1'b0;
    stop_now = 1'b0;
    clean_eff = 1'b0;
    streak_n = s_q.streak;
    s_d.log_v = 1'b0;
    // first stage only feeds the second; the edge is taken after that
    s_d.pin = {s_q.pin[1:0], particle};
    pulse = s_q.pin[1] & ~s_q.pin[2];
    tick = (s_q.div == SEC_LAST);
    s_d.div = tick ? '0 : s_q.div + 32'h00000001;
    // tests time themselves so each lasts exactly its whole seconds;
    // the free-running divider only keeps the time of day
    ttick = (s_q.sub == SEC_LAST);
    s_d.sub = ttick ? '0 : s_q.sub + 32'h00000001;
    // a whole-second step per test, used to land logs on test boundaries
    step = (s_q.tint > s_q.dur) ? s_q.tint : s_q.dur;
    lsum = {1'b0, s_q.lacc} + {1'b0, step};
    if (tick)
    begin
      s_d.now = s_q.now + 32'h00000001;
    end
    // register writes
    if (req.wr)
    begin
      case (req.addr)
        ADR_CTRL: s_d.ctrl = req.wdata[W_CTRL-1:0];
        ADR_DUR: s_d.dur = (req.wdata[15:0] < DUR_MIN) ?
                           DUR_MIN : req.wdata[15:0];
        ADR_TINT: s_d.tint = req.wdata[15:0];
        ADR_LINT: s_d.lint = req.wdata[15:0];
        ADR_IGN: s_d.ign = req.wdata[7:0];
        ADR_CONF: s_d.conf = req.wdata[7:0];
        ADR_TIME: s_d.now = req.wdata;
        ADR_STS: clr = req.wdata[W_EV-1:0];
        ADR_MSK: s_d.msk = req.wdata[W_EV-1:0];
        default: ;
      endcase
    end
    // sequencer
    case (s_q.st)
      TSS_IDLE:
      begin
        if (req.wr && req.addr == ADR_CMD && req.wdata[CMD_START])
        begin
          s_d.st = TSS_RUN;
          s_d.el = '0;
          s_d.sub = '0;
          s_d.icnt = '0;
          s_d.cnt = '0;
          s_d.ndone = '0;
          s_d.streak = '0;
          s_d.lacc = '0;
          s_d.alarm = 1'b0;
          s_d.fault = 1'b0;
        end
      end
      TSS_RUN, TSS_WAIT:
      begin
        if (ttick)
        begin
          s_d.icnt = s_q.icnt + 16'h0001;
        end
        if (s_q.st == TSS_RUN)
        begin
          // the count saturates rather than wrap back under the minimum
          if (pulse && !s_q.ctrl[B_SIM] && s_q.cnt != 16'hFFFF)
          begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
          if (ttick)
          begin
            s_d.el = s_q.el + 16'h0001;
          end
          // test ends after exactly dur whole seconds
          if (ttick && s_d.el == s_q.dur)
          begin
            ev[E_DONE] = 1'b1;
            // simulated tests need no flow and always yield a result
            s_d.rec.count = s_q.ctrl[B_SIM] ? MIN_PARTICLES : s_q.cnt;
            s_d.rec.valid = 1'b1;
            if (s_q.ctrl[B_LFDIS] && s_d.rec.count < MIN_PARTICLES)
            begin
              s_d.rec.valid = 1'b0;
              s_d.fault = 1'b1;
              s_d.alarm = 1'b1;
              ev[E_LOWC] = 1'b1;
            end
            s_d.flow_ok = s_d.rec.valid;
            clean_eff = clean_hit & s_d.rec.valid;
            s_d.rec.clean = clean_eff;
            s_d.rec.serial = SERIAL_NO;
            s_d.rec.stamp = s_q.now;
            // a host time step backwards must not repeat a record key
            if (s_q.tnum != TNUM_RST && s_q.now <= s_q.last.stamp)
            begin
              s_d.rec.stamp = s_q.last.stamp + 32'h00000001;
            end
            s_d.rec.num = s_q.tnum;
            s_d.tnum = s_q.tnum + 16'h0001;
            streak_n = clean_eff ? s_q.streak + 8'h01 : 8'h00;
            s_d.streak = streak_n;
            if (s_q.ctrl[B_STOPC] && clean_eff)
            begin
              stop_now = !s_q.ctrl[B_CONFM] ||
                         streak_n >= s_q.conf;
            end
            if (s_q.ndone != 8'hFF)
            begin
              s_d.ndone = s_q.ndone + 8'h01;
            end
            if (s_q.ndone >= s_q.ign)
            begin
              if (!s_q.ctrl[B_CONT] || stop_now)
              begin
                do_log = 1'b1;
              end
              else if (s_q.ctrl[B_LOGC])
              begin
                if (lsum[15:0] == s_q.lint || s_q.lint == 16'h0000)
                begin
                  do_log = 1'b1;
                  s_d.lacc = '0;
                end
                else if (lsum > {1'b0, s_q.lint})
                begin
                  ev[E_ALIGN] = 1'b1;
                  s_d.lacc = '0;
                end
                else
                begin
                  s_d.lacc = lsum[15:0];
                end
              end
            end
            if (stop_now)
            begin
              s_d.alarm = 1'b1;
              ev[E_CLEAN] = 1'b1;
              s_d.st = TSS_IDLE;
            end
            else if (!s_q.ctrl[B_CONT])
            begin
              s_d.st = TSS_IDLE;
            end
            else if (s_q.tint > s_q.dur)
            begin
              s_d.st = TSS_WAIT;
            end
            else
            begin
              s_d.st = TSS_RUN;
              s_d.sub = '0;
              s_d.el = '0;
              s_d.icnt = '0;
              s_d.cnt = '0;
            end
          end
        end
        else if (s_d.icnt >= s_q.tint)
        begin
          s_d.st = TSS_RUN;
          s_d.sub = '0;
          s_d.el = '0;
          s_d.icnt = '0;
          s_d.cnt = '0;
        end
        // a host stop drops the running test without a record
        if (req.wr && req.addr == ADR_CMD && req.wdata[CMD_STOP])
        begin
          s_d.st = TSS_IDLE;
        end
      end
      default: s_d.st = TSS_IDLE;
    endcase
    s_d.testing = (s_d.st == TSS_RUN);
    if (do_log)
    begin
      s_d.log_v = 1'b1;
      ev[E_LOG] = 1'b1;
    end
    if (ev[E_DONE])
    begin
      s_d.last = s_d.rec;
    end
    // set wins over a simultaneous write-one clear
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.irq = |(s_d.sts & s_d.msk);
    // reads answer the cycle after the strobe
    s_d.rdata = '0;
    if (req.rd)
    begin
      case (req.addr)
        ADR_CTRL: s_d.rdata = 32'(s_q.ctrl);
        ADR_DUR: s_d.rdata = 32'(s_q.dur);
        ADR_TINT: s_d.rdata = 32'(s_q.tint);
        ADR_LINT: s_d.rdata = 32'(s_q.lint);
        ADR_IGN: s_d.rdata = 32'(s_q.ign);
        ADR_CONF: s_d.rdata = 32'(s_q.conf);
        ADR_TIME: s_d.rdata = s_q.now;
        ADR_TNUM: s_d.rdata = 32'(s_q.tnum);
        ADR_STS: s_d.rdata = 32'(s_q.sts);
        ADR_MSK: s_d.rdata = 32'(s_q.msk);
        ADR_RES: s_d.rdata = {s_q.last.count, 8'h00,
                              5'h00, s_q.last.clean,
                              s_q.last.valid,
                              s_q.st != TSS_IDLE};
        ADR_SER: s_d.rdata = SERIAL_NO;
        ADR_FW: s_d.rdata = FW_VER;
        ADR_CALL: s_d.rdata = CAL_LAST;
        ADR_CALD: s_d.rdata = CAL_DUE;
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.dur <= DUR_RST;
      s_q.tnum <= TNUM_RST;
      s_q.st <= TSS_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign fmt = s_q.ctrl[B_FMT +: W_FMT];
  assign testing = s_q.testing;
  assign alarm = s_q.alarm;
  assign fault = s_q.fault;
  assign flow_ok = s_q.flow_ok;
  assign log_v = s_q.log_v;
  assign log_rec = s_q.rec;
  assign irq = s_q.irq;
endmodule : tss_core

/* tss_core_monitor.sv */
// assertion checker watching the sequencer ports
`timescale 1ns/1ps
module tss_core_monitor
  import tss_pkg::*;
#(
  parameter logic [31:0] SERIAL_NO = 32'h00000001
) (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire tss_pkg::tss_req_s req, // register request
  input wire logic [31:0] rdata, // read data
  input wire logic testing, // test active
  input wire logic alarm, // alarm level
  input wire logic fault, // fault level
  input wire logic log_v, // log strobe
  input wire tss_pkg::tss_rec_s log_rec // log record
);
  logic start_cmd;
  logic stop_cmd;
  logic [3:0] run_len;
  assign start_cmd = req.wr && req.addr == ADR_CMD && req.wdata[CMD_START];
  assign stop_cmd = req.wr && req.addr == ADR_CMD && req.wdata[CMD_STOP];
  // cycles of the current run, saturating; a host stop may cut it short
  always_ff @(posedge clk)
  begin
    if (reset || !testing)
    begin
      run_len <= 4'h0;
    end
    else if (run_len != 4'hF)
    begin
      run_len <= run_len + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0)
    else $error("read data not zero outside reply");
  a_min_length: assert property
    ($fell(testing) && !$past(stop_cmd) |-> run_len >= 4'h8)
    else $error("test shorter than its duration");
  a_start_clear: assert property
    ($rose(testing) && $past(start_cmd) |-> !fault && !alarm)
    else $error("alarm or fault kept across start");
  a_log_pulse: assert property (log_v |=> !log_v)
    else $error("log strobe longer than one cycle");
  a_log_key: assert property (log_v |-> log_rec.serial == SERIAL_NO)
    else $error("record serial wrong");
  a_fault_alarm: assert property (fault |-> alarm)
    else $error("fault without alarm");
  a_low_fault: assert property (log_v && !log_rec.valid |-> ##[0:1] fault)
    else $error("invalid result without fault");
  a_clean_ok: assert property (log_v && log_rec.clean |-> log_rec.valid)
    else $error("clean result not valid");
  a_valid_count: assert property
    (log_v && log_rec.count >= MIN_PARTICLES |-> log_rec.valid)
    else $error("enough particles but invalid");
  c_log: cover property (log_v && log_rec.valid);
  c_fault: cover property ($rose(fault));
  c_clean: cover property ($fell(testing) && alarm && !fault);
endmodule : tss_core_monitor

bind tss_core tss_core_monitor #(.SERIAL_NO(SERIAL_NO)) u_mon (
  .clk(clk), .reset(reset), .req(req), .rdata(rdata), .testing(testing),
  .alarm(alarm), .fault(fault), .log_v(log_v), .log_rec(log_rec));

/* tss_host.sv */
// host computer model driving the register port
`timescale 1ns/1ps
module tss_host
  import tss_pkg::*;
(
  input wire logic clk, // clock
  output tss_pkg::tss_req_s req, // register request
  input wire logic [31:0] rdata // read data
);
  initial req <= '0;
  // a strobe always begins a fresh cycle so no field is driven twice
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
endmodule : tss_host

/* testbench.sv */
// self-checking bench for the test schedule sequencer
`timescale 1ns/1ps
module testbench;
  import tss_pkg::*;
  localparam logic [31:0] SER = 32'h0000A5C3; // arbitrary value
  localparam logic [31:0] FWV = 32'h00000203; // arbitrary value
  localparam logic [31:0] CLA = 32'h00000111; // arbitrary value
  localparam logic [31:0] CDU = 32'h00000222; // arbitrary value
  logic clk, reset, particle, clean_hit, testing, alarm, fault, flow_ok;
  logic log_v, irq;
  logic [1:0] fmt;
  logic [31:0] rdata, d, e;
  tss_req_s req;
  tss_rec_s log_rec;
  int fail_count = 0;
  int n_checks = 0;
  tss_core #(.SEC_CYCLES(8), .SERIAL_NO(SER), .FW_VER(FWV),
    .CAL_LAST(CLA), .CAL_DUE(CDU)) u_dut (
    .clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .particle(particle), .clean_hit(clean_hit), .fmt(fmt),
    .testing(testing), .alarm(alarm), .fault(fault), .flow_ok(flow_ok),
    .log_v(log_v), .log_rec(log_rec), .irq(irq));
  tss_host u_host (.clk(clk), .req(req), .rdata(rdata));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic wlog(output int i);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end while (log_v !== 1'b1 && i < 600);
    if (log_v !== 1'b1)
    begin
      chk("log wait", 0, 1);
      test_done();
    end
  endtask : wlog
  task automatic start(input logic [31:0] c);
    u_host.wr(ADR_CMD, 32'h2);
    u_host.wr(ADR_CTRL, c);
    u_host.wr(ADR_CMD, 32'h1);
  endtask : start
  task automatic t_id;
    u_host.rd(ADR_TNUM, d);
    chk("test number", d, 32'(TNUM_RST));
    u_host.rd(ADR_DUR, d);
    chk("duration", d, 32'(DUR_RST));
    u_host.rd(ADR_SER, d);
    chk("serial", d, SER);
    u_host.rd(ADR_FW, d);
    chk("firmware", d, FWV);
    u_host.rd(ADR_CALL, d);
    chk("last calibration", d, CLA);
    u_host.rd(ADR_CALD, d);
    chk("calibration due", d, CDU);
    u_host.wr(ADR_TIME, 32'h100);
    u_host.rd(ADR_TIME, d);
    chk("time", d & ~32'h1, 32'h100);
  endtask : t_id
  task automatic t_low;
    int i;
    u_host.wr(ADR_DUR, 32'h4);
    u_host.wr(ADR_MSK, 32'h1);
    u_host.wr(ADR_TIME, 32'h40);
    start(32'h1 << B_LFDIS);
    repeat (3)
    begin
      particle <= 1'b1;
      repeat (2) @(posedge clk);
      particle <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wlog(i);
    chk("count", 32'(log_rec.count), 32'h3);
    chk("valid", 32'(log_rec.valid), 32'h0);
    chk("stamp", log_rec.stamp & ~32'h7, 32'h40);
    chk("serial key", log_rec.serial, SER);
    repeat (2) @(posedge clk);
    #1;
    chk("alarms", {fault, alarm, flow_ok, irq}, 32'hD);
    u_host.wr(ADR_STS, 32'h1F);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", 32'(irq), 32'h0);
  endtask : t_low
  task automatic t_sim;
    int i;
    u_host.wr(ADR_DUR, 32'h2);
    start(32'hB0);
    wlog(i);
    chk("sim count", 32'(log_rec.count), 32'(MIN_PARTICLES));
    chk("sim valid", {log_rec.valid, fault}, 32'h2);
    chk("format", 32'(fmt), 32'h2);
    u_host.rd(ADR_RES, d);
    chk("result", d, {MIN_PARTICLES, 16'h0002});
  endtask : t_sim
  task automatic t_clean;
    int n, f;
    logic pt;
    @(posedge clk);
    clean_hit <= 1'b1;
    u_host.wr(ADR_CONF, 32'h2);
    u_host.wr(ADR_TINT, 32'h0);
    u_host.rd(ADR_TNUM, e);
    start(32'h1D);
    n = 0;
    f = 0;
    pt = 1'b1;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      n += int'(log_v);
      f += int'(pt && !testing);
      pt = testing;
    end
    chk("final logs", n, 1);
    chk("stops", f, 1);
    chk("clean alarm", 32'(alarm), 32'h1);
    chk("clean record", {log_rec.clean, log_rec.valid}, 32'h3);
    chk("record number", 32'(log_rec.num), e + 32'h1);
    u_host.rd(ADR_TNUM, d);
    chk("confirm tests", d - e, 32'h2);
    @(posedge clk);
    clean_hit <= 1'b0;
  endtask : t_clean
  task automatic t_ign;
    int i;
    u_host.wr(ADR_IGN, 32'h2);
    u_host.wr(ADR_TINT, 32'h0);
    u_host.wr(ADR_LINT, 32'h0);
    u_host.rd(ADR_TNUM, e);
    start(32'h13);
    wlog(i);
    chk("first logged", 32'(log_rec.num) - e, 32'h2);
    u_host.wr(ADR_CMD, 32'h2);
    u_host.wr(ADR_IGN, 32'h0);
  endtask : t_ign
  task automatic t_rst;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    u_host.rd(ADR_TNUM, d);
    chk("number after reset", d, 32'(TNUM_RST));
    chk("idle after reset", {testing, alarm, fault, irq}, 32'h0);
  endtask : t_rst
  task automatic t_cont;
    int i;
    u_host.wr(ADR_TINT, 32'h4);
    u_host.wr(ADR_LINT, 32'h8);
    start(32'h13);
    wlog(i);
    wlog(i);
    chk("log spacing", i, 64);
    u_host.wr(ADR_LINT, 32'h6);
    u_host.wr(ADR_STS, 32'h1F);
    start(32'h13);
    repeat (100) @(posedge clk);
    u_host.rd(ADR_STS, d);
    chk("align error", d & 32'h10, 32'h10);
    u_host.wr(ADR_CMD, 32'h2);
  endtask : t_cont
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    reset <= 1'b1;
    particle <= 1'b0;
    clean_hit <= 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_id();
    t_low();
    t_sim();
    t_clean();
    t_ign();
    t_cont();
    t_rst();
    test_done();
  end
endmodule : testbench
